/* hw/cot_timer.sv */
// Compare output timer: 16-bit up-counter with four compare channels,
// AHB-Lite register slave, waveform pins and two interrupt requests.
// Assumes pins ext_count_clock_pin and cutoff pin are asynchronous.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module cot_timer (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic ext_count_clock_pin_in,
  input wire logic ext_int_zero_n_in,
  output logic [3:0] wave_pin_out,
  output logic [3:0] wave_pin_oe_out,
  output logic match_irq_out,
  output logic overflow_irq_out
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl_one;
    logic [7:0] ab_io;
    logic [7:0] cd_io;
    logic [7:0] ctrl_two;
    logic [7:0] mode;
    logic [7:0] out_dis;
    logic [15:0] up_counter;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cmp_c;
    logic [15:0] cmp_d;
    logic [4:0] prescale;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] cut_sync;
    logic [3:0] match_hold;
    logic tick_d;
    logic load_init;
    logic [1:0] irq;
    cot_pkg::cot_aphase_s aph;
    logic [31:0] rdata;
  } cot_state_s;
  cot_state_s st_r;
  cot_state_s st_nxt;

  logic tick;
  logic [3:0] eq;
  logic [3:0] pin_match;
  logic [3:0] pin_level;
  logic [1:0] act [4];
  logic [2:0] src;
  logic wr_go;
  logic [11:0] idx;
  logic [31:0] rd_mux;
  logic route_c;
  logic route_d;
  logic [1:0] irq_ev;

  assign src = st_r.ctrl_one[cot_pkg::POS_SRC_LO +: 3];
  assign route_c = ~st_r.cd_io[3];
  assign route_d = ~st_r.cd_io[7];
  assign act[0] = st_r.ab_io[1:0];
  assign act[1] = st_r.ab_io[5:4];
  assign act[2] = st_r.cd_io[1:0];
  assign act[3] = st_r.cd_io[5:4];

  // ---------------------------------------------------------------
  // Count source tick
  // ---------------------------------------------------------------
  // Prescaler runs freely so a divided tick is a single-cycle pulse
  always_comb begin
    unique case (src)
      cot_pkg::SRC_DIV1: tick = 1'b1;
      cot_pkg::SRC_DIV2: tick = (st_r.prescale[0] == 1'b1);
      cot_pkg::SRC_DIV4: tick = (st_r.prescale[1:0] == 2'h3);
      cot_pkg::SRC_DIV8: tick = (st_r.prescale[2:0] == 3'h7);
      cot_pkg::SRC_DIV32: tick = (st_r.prescale == cot_pkg::DIV_MAX);
      cot_pkg::SRC_EXT: tick = st_r.ext_sync[1] & ~st_r.ext_prev;
      default: tick = 1'b0; // Unused codes never count
    endcase
  end

  // Equality compare, sampled only on a count tick
  assign eq[0] = (st_r.up_counter == st_r.cmp_a);
  assign eq[1] = (st_r.up_counter == st_r.cmp_b);
  assign eq[2] = (st_r.up_counter == st_r.cmp_c);
  assign eq[3] = (st_r.up_counter == st_r.cmp_d);

  // Channel C/D feed pins A/B when redirected (cd_io bit 3/7 clear), whatever the buffer mode
  always_comb begin
    pin_match[0] = st_r.match_hold[0] | (route_c & st_r.match_hold[2]);
    pin_match[1] = st_r.match_hold[1] | (route_d & st_r.match_hold[3]);
    pin_match[2] = st_r.match_hold[2] & ~route_c;
    pin_match[3] = st_r.match_hold[3] & ~route_d;
  end

  // Bus decode of the data phase
  assign wr_go = st_r.aph.sel & st_r.aph.write;
  assign idx = st_r.aph.addr[13:2];

  // Read multiplexer; ONES_AB_IO and ONES_CTRL_TWO bits read as one, other unassigned bits zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr_in[13:2])
      cot_pkg::IDX_CTRL_ONE: rd_mux[7:0] = st_r.ctrl_one;
      cot_pkg::IDX_AB_IO: rd_mux[7:0] = st_r.ab_io | cot_pkg::ONES_AB_IO;
      cot_pkg::IDX_CD_IO: rd_mux[7:0] = st_r.cd_io;
      cot_pkg::IDX_CTRL_TWO: rd_mux[7:0] = st_r.ctrl_two | cot_pkg::ONES_CTRL_TWO;
      cot_pkg::IDX_MODE: rd_mux[7:0] = st_r.mode;
      cot_pkg::IDX_COUNTER: rd_mux[15:0] = st_r.up_counter;
      cot_pkg::IDX_CMP_A: rd_mux[15:0] = st_r.cmp_a;
      cot_pkg::IDX_CMP_B: rd_mux[15:0] = st_r.cmp_b;
      cot_pkg::IDX_CMP_C: rd_mux[15:0] = st_r.cmp_c;
      cot_pkg::IDX_CMP_D: rd_mux[15:0] = st_r.cmp_d;
      cot_pkg::IDX_OUT_EN: rd_mux[7:0] = st_r.out_dis;
      cot_pkg::IDX_STATUS: rd_mux[1:0] = st_r.irq;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prescale = st_r.prescale + 5'h01;
    st_nxt.ext_sync = {st_r.ext_sync[0], ext_count_clock_pin_in};
    st_nxt.ext_prev = st_r.ext_sync[1];
    st_nxt.cut_sync = {st_r.cut_sync[0], ext_int_zero_n_in};
    st_nxt.match_hold = '0;
    st_nxt.tick_d = 1'b0;
    st_nxt.load_init = 1'b0;
    st_nxt.irq = st_r.irq;
    irq_ev = 2'h0;
    // Counting and matching
    if (st_r.mode[cot_pkg::POS_RUN] && tick) begin
      st_nxt.match_hold = eq;
      if (|eq) begin
        st_nxt.irq[0] = 1'b1;
        irq_ev[0] = 1'b1;
      end
      if (st_r.ctrl_one[cot_pkg::POS_CLEAR_SEL] && eq[0]) begin
        st_nxt.up_counter = 16'h0000;
      end else begin
        st_nxt.up_counter = st_r.up_counter + 16'h0001;
        if (st_r.up_counter == 16'hFFFF) begin
          st_nxt.irq[1] = 1'b1;
          irq_ev[1] = 1'b1;
        end
      end
      // Buffered values move into A/B on their match
      if (st_r.mode[cot_pkg::POS_BUF_C] && eq[0]) begin
        st_nxt.cmp_a = st_r.cmp_c;
      end
      if (st_r.mode[cot_pkg::POS_BUF_D] && eq[1]) begin
        st_nxt.cmp_b = st_r.cmp_d;
      end
      if (st_r.ctrl_two[cot_pkg::POS_STOP_MATCH] && eq[0]) begin
        st_nxt.mode[cot_pkg::POS_RUN] = 1'b0;
      end
    end
    // Address phase capture
    if (hready_in) begin
      st_nxt.aph.sel = hsel_in & htrans_in[1];
      st_nxt.aph.write = hwrite_in;
      st_nxt.aph.addr = haddr_in[cot_pkg::ADDR_W-1:0];
    end
    st_nxt.rdata = rd_mux;
    // Register writes in the data phase
    if (wr_go) begin
      unique case (idx)
        cot_pkg::IDX_CTRL_ONE: begin
          st_nxt.ctrl_one = hwdata_in[7:0];
          st_nxt.load_init = 1'b1;
        end
        cot_pkg::IDX_AB_IO: st_nxt.ab_io = hwdata_in[7:0] & ~cot_pkg::ONES_AB_IO;
        cot_pkg::IDX_CD_IO: st_nxt.cd_io = hwdata_in[7:0];
        cot_pkg::IDX_CTRL_TWO: st_nxt.ctrl_two = hwdata_in[7:0] & ~cot_pkg::ONES_CTRL_TWO;
        cot_pkg::IDX_MODE: st_nxt.mode = hwdata_in[7:0];
        cot_pkg::IDX_COUNTER: st_nxt.up_counter = hwdata_in[15:0];
        cot_pkg::IDX_CMP_A: st_nxt.cmp_a = hwdata_in[15:0];
        cot_pkg::IDX_CMP_B: st_nxt.cmp_b = hwdata_in[15:0];
        cot_pkg::IDX_CMP_C: st_nxt.cmp_c = hwdata_in[15:0];
        cot_pkg::IDX_CMP_D: st_nxt.cmp_d = hwdata_in[15:0];
        cot_pkg::IDX_OUT_EN: st_nxt.out_dis = hwdata_in[7:0];
        cot_pkg::IDX_STATUS: begin
          // Write one to clear; a same-cycle event still sets the flag
          st_nxt.irq = (st_r.irq & ~hwdata_in[1:0]) | irq_ev;
        end
        default: st_nxt.ctrl_one = st_r.ctrl_one;
      endcase
    end
    // Cutoff after the writes, so a same-cycle write cannot re-enable pins
    if (st_r.out_dis[cot_pkg::POS_CUTOFF_EN] && !st_r.cut_sync[1]) begin
      st_nxt.out_dis[3:0] = 4'hF;
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= '0;
      st_r.ctrl_one <= cot_pkg::RST_CTRL_ONE;
      st_r.ab_io <= cot_pkg::RST_AB_IO & ~cot_pkg::ONES_AB_IO;
      st_r.cd_io <= cot_pkg::RST_CD_IO;
      st_r.ctrl_two <= cot_pkg::RST_CTRL_TWO & ~cot_pkg::ONES_CTRL_TWO;
      st_r.mode <= cot_pkg::RST_MODE;
      st_r.out_dis <= cot_pkg::RST_OUT_EN;
      st_r.cmp_a <= cot_pkg::RST_CMP;
      st_r.cmp_b <= cot_pkg::RST_CMP;
      st_r.cmp_c <= cot_pkg::RST_CMP;
      st_r.cmp_d <= cot_pkg::RST_CMP;
      st_r.ext_sync <= 2'h3;
      st_r.ext_prev <= 1'b1;
      st_r.cut_sync <= 2'h3;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Waveform pins
  // ---------------------------------------------------------------
  // One pin channel per output; pin enable needs action set and not disabled
  for (genvar i = 0; i < 4; i++) begin : g_pin
    cot_pin_channel u_pin (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .load_init_in(st_r.load_init),
      .init_level_in(st_r.ctrl_one[i]),
      .action_in(act[i]),
      .match_in(pin_match[i]),
      .level_out(pin_level[i])
    );
    assign wave_pin_oe_out[i] = (act[i] != cot_pkg::ACT_NONE) & ~st_r.out_dis[i];
  end

  assign wave_pin_out = pin_level;
  assign hrdata_out = st_r.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign match_irq_out = st_r.irq[0];
  assign overflow_irq_out = st_r.irq[1];
endmodule

/* hw/cot_pkg.sv */
// Package for the compare output timer: register map, field positions,
// reset values and shared carrier types.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
package cot_pkg;
  // ---------------------------------------------------------------
  // Register indices (printed offsets) and the bus address width
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_CTRL_ONE = 12'h121;
  localparam logic [11:0] IDX_AB_IO = 12'h124;
  localparam logic [11:0] IDX_CD_IO = 12'h125;
  localparam logic [11:0] IDX_CTRL_TWO = 12'h130;
  localparam logic [11:0] IDX_MODE = 12'h120;
  localparam logic [11:0] IDX_COUNTER = 12'h126;
  localparam logic [11:0] IDX_CMP_A = 12'h128;
  localparam logic [11:0] IDX_CMP_B = 12'h129;
  localparam logic [11:0] IDX_CMP_C = 12'h12A;
  localparam logic [11:0] IDX_CMP_D = 12'h12B;
  localparam logic [11:0] IDX_OUT_EN = 12'h12C;
  localparam logic [11:0] IDX_STATUS = 12'h12D;
  localparam int ADDR_W = 14;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] RST_AB_IO = 8'h88;
  localparam logic [7:0] RST_CD_IO = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO = 8'h18;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_OUT_EN = 8'h0F;
  localparam logic [15:0] RST_CMP = 16'hFFFF;
  // Unassigned bits that read as one
  localparam logic [7:0] ONES_AB_IO = 8'h80;
  localparam logic [7:0] ONES_CTRL_TWO = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int POS_CLEAR_SEL = 7;
  localparam int POS_SRC_LO = 4;
  localparam int POS_STOP_MATCH = 5;
  localparam int POS_RUN = 0;
  localparam int POS_BUF_C = 2;
  localparam int POS_BUF_D = 3;
  localparam int POS_CUTOFF_EN = 7;
  // Count source codes
  localparam logic [2:0] SRC_DIV1 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV8 = 3'h3;
  localparam logic [2:0] SRC_DIV32 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [4:0] DIV_MAX = 5'h1F;
  // Match actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] drive;
  } cot_pins_s;
  typedef struct packed {
    logic sel;
    logic write;
    logic [ADDR_W-1:0] addr;
  } cot_aphase_s;
endpackage

/* hw/cot_pin_channel.sv */
// One waveform output pin: initial level load and match actions.
// Assumes match strobes are already qualified by the counter tick.
`timescale 1ns/1ps
module cot_pin_channel (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic load_init_in,
  input wire logic init_level_in,
  input wire logic [1:0] action_in,
  input wire logic match_in,
  output logic level_out
);
  typedef struct packed {
    logic level;
  } cot_pin_state_s;
  cot_pin_state_s st_r;
  cot_pin_state_s st_nxt;

  // Initial level load takes priority; action code zero leaves pin alone
  always_comb begin
    st_nxt = st_r;
    if (load_init_in) begin
      st_nxt.level = init_level_in;
    end else if (match_in) begin
      unique case (action_in)
        cot_pkg::ACT_NONE: st_nxt.level = st_r.level;
        cot_pkg::ACT_LOW: st_nxt.level = 1'b0;
        cot_pkg::ACT_HIGH: st_nxt.level = 1'b1;
        cot_pkg::ACT_TOGGLE: st_nxt.level = ~st_r.level;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level_out = st_r.level;
endmodule

/* verif/cot_timer_monitor.sv */
// Checker for the compare output timer's bus and request ports.
// Assumes it is bound into cot_timer and sees only that module's ports.
`timescale 1ns/1ps
module cot_timer_monitor (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic [3:0] wave_pin_oe_out,
  input wire logic match_irq_out,
  input wire logic overflow_irq_out
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic take;
  logic stat_wr_r;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Taken address phase; the status write is kept for its data phase
  assign take = hsel_in && htrans_in[1] && hready_in;
  always_ff @(posedge clock_in) begin
    stat_wr_r <= take && hwrite_in && (haddr_in[13:2] == cot_pkg::IDX_STATUS);
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_ready_high: assert property (hreadyout_out == 1'b1)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (hresp_out == 1'b0)
    else $error("slave answered with an error");
  a_reset_quiet: assert property ($fell(rst_in) |->
    (wave_pin_oe_out == 4'h0) && !match_irq_out && !overflow_irq_out)
    else $error("pins or requests active out of reset");
  a_match_clear: assert property ($fell(match_irq_out) |-> $past(stat_wr_r))
    else $error("match request dropped without a clear");
  a_ovf_clear: assert property ($fell(overflow_irq_out) |-> $past(stat_wr_r))
    else $error("overflow request dropped without a clear");
  a_unmapped_zero: assert property (take && !hwrite_in &&
    haddr_in[13:2] == 12'h100 |=> hrdata_out == 32'h0)
    else $error("unmapped slot read not zero");
  a_ab_ones: assert property (take && !hwrite_in &&
    haddr_in[13:2] == cot_pkg::IDX_AB_IO |=> hrdata_out[31:7] == 25'h1)
    else $error("channel ab control spare bit wrong");
  a_two_ones: assert property (take && !hwrite_in &&
    haddr_in[13:2] == cot_pkg::IDX_CTRL_TWO |=> hrdata_out[4:3] == 2'h3)
    else $error("control two spare bits not one");
endmodule

/* verif/cot_pin_load.sv */
// Far-side load on the four waveform pins, each with a pull-up.
// Assumes a released pin floats high and the bench clears the edge count.
`timescale 1ns/1ps
module cot_pin_load (
  input wire logic clock_in,
  input wire logic [3:0] pin_in,
  input wire logic [3:0] oe_in,
  input wire logic clear_in,
  output logic [3:0] line_out,
  output logic [7:0] edges_a_out
);
  logic [3:0] line_q;
  // Released pins go to the pull-up level, never the last driven one
  assign line_out = (pin_in & oe_in) | ~oe_in;
  // Edges seen on line A, for single-toggle checks
  always_ff @(posedge clock_in) begin
    line_q <= line_out;
    if (clear_in) begin
      edges_a_out <= 8'h00;
    end else if (line_q[0] != line_out[0]) begin
      edges_a_out <= edges_a_out + 8'h01;
    end
  end
endmodule

/* verif/cot_timer_tb_top.sv */
// Bench for the compare output timer: AHB-Lite register tasks, wave checks.
// Assumes the package, the timer, the pin load and the monitor compile first.
`timescale 1ns/1ps
bind cot_timer cot_timer_monitor mon (.clock_in, .rst_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .wave_pin_oe_out,
  .match_irq_out, .overflow_irq_out);
module cot_timer_tb_top;
  localparam logic [11:0] C1 = cot_pkg::IDX_CTRL_ONE;
  localparam logic [11:0] AB = cot_pkg::IDX_AB_IO;
  localparam logic [11:0] CD = cot_pkg::IDX_CD_IO;
  localparam logic [11:0] C2 = cot_pkg::IDX_CTRL_TWO;
  localparam logic [11:0] MD = cot_pkg::IDX_MODE;
  localparam logic [11:0] CNT = cot_pkg::IDX_COUNTER;
  localparam logic [11:0] CA = cot_pkg::IDX_CMP_A;
  localparam logic [11:0] ST = cot_pkg::IDX_STATUS;
  logic clock_in, rst_in, hsel, hwrite, hready, ext_clk, external_interrupt_zero_pin_n, clr, mirq, oirq;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [3:0] pins, oe, line;
  logic [7:0] edges;
  int mismatches = 0;
  int tests_run = 0;
  int div [5] = '{1, 2, 4, 8, 32};
  cot_timer uut (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
    .ext_count_clock_pin_in(ext_clk), .ext_int_zero_n_in(external_interrupt_zero_pin_n), .wave_pin_out(pins),
    .wave_pin_oe_out(oe), .match_irq_out(mirq), .overflow_irq_out(oirq));
  cot_pin_load load (.clock_in(clock_in), .pin_in(pins), .oe_in(oe), .clear_in(clr),
    .line_out(line), .edges_a_out(edges));
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for hready; a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t bus timeout", $time);
      wrap_up();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] i, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge clock_in);
    hsel <= 1'b1;
    haddr <= {18'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask
  task automatic rdc(input logic [11:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 32'h0, r);
    chk(r, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {hsel, hwrite, ext_clk, haddr, hwdata, htrans} = '0;
    external_interrupt_zero_pin_n = 1'b1;
    clr = 1'b1;
    rst_in = 1'b1;
    tick(10);
    rst_in <= 1'b0;
    clr <= 1'b0;
    // Reset values, read-as-one bits, unmapped slot, counter access
    rdc(C1, cot_pkg::RST_CTRL_ONE);
    rdc(AB, cot_pkg::RST_AB_IO);
    rdc(CD, cot_pkg::RST_CD_IO);
    rdc(12'h100, 32'h0);
    wr(AB, 32'h0);
    rdc(AB, cot_pkg::ONES_AB_IO);
    wr(C2, 32'h0);
    rdc(C2, cot_pkg::ONES_CTRL_TWO);
    wr(CNT, 32'h1234);
    rdc(CNT, 32'h1234);
    chk(oe, 32'h0);
    $display("Test registers done");
    // Each divided source; a halted counter holds its value
    for (int i = 0; i < 5; i++) begin
      wr(MD, 32'h0);
      wr(CNT, 32'h0);
      wr(C1, i << 4);
      wr(MD, 32'h1);
      tick(320);
      wr(MD, 32'h0);
      xfer(1'b0, CNT, 32'h0, v);
      chk({31'h0, v >= 320 / div[i] - 1 && v <= 330 / div[i] + 1}, 32'h1);
      rdc(CNT, v);
    end
    wr(CNT, 32'h0);
    wr(C1, 32'h50);
    wr(MD, 32'h1);
    repeat (6) begin
      ext_clk <= 1'b1;
      tick(4);
      ext_clk <= 1'b0;
      tick(4);
    end
    tick(6);
    rdc(CNT, 32'h6);
    wr(MD, 32'h0);
    $display("Test sources done");
    // A low, B high, C toggle, D released; A and C start high
    wr(CNT, 32'h0);
    wr(cot_pkg::IDX_OUT_EN, 32'h0);
    wr(AB, 32'h29);
    wr(CD, 32'h8B);
    wr(CA, 32'h20);
    wr(cot_pkg::IDX_CMP_B, 32'h30);
    wr(cot_pkg::IDX_CMP_C, 32'h40);
    wr(cot_pkg::IDX_CMP_D, 32'h50);
    wr(C1, 32'h05);
    tick(3);
    chk(pins, 32'h5);
    chk(oe, 32'h7);
    chk(line, 32'hD);
    wr(MD, 32'h1);
    tick(96);
    wr(MD, 32'h0);
    chk(pins, 32'h2);
    chk(mirq, 32'h1);
    tick(20);
    chk(pins, 32'h2);
    $display("Test actions done");
    // Clear on channel A match keeps the count short of overflow
    wr(ST, 32'h3);
    tick(1);
    chk(mirq, 32'h0);
    wr(CNT, 32'h0);
    wr(C1, 32'h80);
    wr(CA, 32'h10);
    wr(MD, 32'h1);
    tick(200);
    xfer(1'b0, CNT, 32'h0, v);
    wr(MD, 32'h0);
    chk({31'h0, v <= 32'h10}, 32'h1);
    chk(oirq, 32'h0);
    // Free run through the top of the count
    wr(C1, 32'h0);
    wr(CNT, 32'hFFF0);
    wr(MD, 32'h1);
    tick(30);
    wr(MD, 32'h0);
    xfer(1'b0, CNT, 32'h0, v);
    chk(oirq, 32'h1);
    chk({31'h0, v >= 32'h8 && v <= 32'h20}, 32'h1);
    $display("Test clear and wrap done");
    // Stop on channel A match after a single toggle
    wr(CNT, 32'h0);
    wr(AB, 32'h0B);
    wr(C2, 32'h20);
    wr(CA, 32'h20);
    wr(C1, 32'h0);
    clr <= 1'b1;
    tick(3);
    clr <= 1'b0;
    wr(MD, 32'h1);
    tick(80);
    xfer(1'b0, CNT, 32'h0, v);
    rdc(CNT, v);
    chk({31'h0, v <= 32'h21}, 32'h1);
    chk(pins[0], 32'h1);
    chk(edges, 32'h1);
    $display("Test stop on match done");
    // Channel C redirected onto pin A: two toggles from A and C matches
    wr(C2, 32'h0);
    wr(CNT, 32'h0);
    wr(CD, 32'h03);
    wr(CA, 32'h10);
    wr(cot_pkg::IDX_CMP_C, 32'h20);
    wr(C1, 32'h0);
    clr <= 1'b1;
    tick(3);
    clr <= 1'b0;
    wr(MD, 32'h1);
    tick(60);
    wr(MD, 32'h0);
    chk(edges, 32'h2);
    chk(pins[0], 32'h0);
    // Channel C buffers the next channel A value
    wr(CD, 32'h08);
    wr(CNT, 32'h0);
    wr(CA, 32'h10);
    wr(cot_pkg::IDX_CMP_C, 32'h30);
    wr(MD, 32'h5);
    tick(20);
    wr(MD, 32'h4);
    rdc(CA, 32'h30);
    wr(MD, 32'h0);
    // Forced cutoff by a low level on the cutoff pin
    wr(cot_pkg::IDX_OUT_EN, 32'h80);
    chk(oe[0], 32'h1);
    external_interrupt_zero_pin_n <= 1'b0;
    tick(4);
    chk(oe, 32'h0);
    external_interrupt_zero_pin_n <= 1'b1;
    rdc(cot_pkg::IDX_OUT_EN, 32'h8F);
    $display("Test redirect buffer cutoff done");
    wrap_up();
  end
endmodule
